// ### ats_params.svh
// constants for the antenna tuner servo sequencer
`ifndef ATS_PARAMS_SVH
`define ATS_PARAMS_SVH
`define ATS_CLK_PERIOD_NS 5
`define ATS_TIMEOUT_MS    20
`define ATS_TIMEOUT_CYC   ((`ATS_TIMEOUT_MS * 1000000) / `ATS_CLK_PERIOD_NS)
`define ATS_BRAKE_US      10
`define ATS_BRAKE_CYC     ((`ATS_BRAKE_US * 1000 + `ATS_CLK_PERIOD_NS - 1) / `ATS_CLK_PERIOD_NS)
`define ATS_LMIN_US       20
`define ATS_LMIN_CYC      ((`ATS_LMIN_US * 1000 + `ATS_CLK_PERIOD_NS - 1) / `ATS_CLK_PERIOD_NS)
`define ATS_CNT_W         12
`define ATS_ADDR_W        8
`define ATS_REG_CTRL      8'h00
`define ATS_REG_TIMEOUT   8'h04
`define ATS_REG_STATUS    8'h08
`define ATS_CTRL_TUNE_BIT 0
`define ATS_RESP_OKAY     2'b00
`define ATS_RESP_SLVERR   2'b10
`define ATS_ONE_CNT       12'h001
`define ATS_ONE_TMR       32'h0000_0001
`endif

// ### ats_pkg.sv
// types for the antenna tuner servo sequencer
`default_nettype none
`include "ats_params.svh"
package ats_pkg;
	typedef struct packed {
		logic tune_request;
		logic switched_low_supply_sense;
		logic nominal_supply_sense;
		logic rf_present;
		logic refl_over;
		logic below_level;
		logic below_pulse_n;
		logic phase_pos;
		logic phase_neg;
		logic amp_hi;
		logic amp_lo;
		logic ind_min;
		logic ind_max;
		logic cap_max;
	} ats_det_t;

	typedef struct packed {
		logic cap_dec;
		logic cap_inc;
		logic ind_inc;
		logic ind_dec;
		logic brake;
		logic atten_relay;
		logic tuning_lamp;
		logic fault_lamp;
		logic lmin_cmax;
		logic hangup;
	} ats_drv_t;

	typedef struct packed {
		ats_det_t                s1;
		ats_det_t                s2;
		ats_det_t                s3;
		logic                    tuning;
		logic                    fault;
		logic                    cap_home;
		logic                    ind_home;
		logic                    ind_force;
		logic                    max_flag;
		logic                    sw_tune;
		logic [31:0]             timer;
		logic [31:0]             tmo;
		logic [`ATS_CNT_W-1:0]   brake_cnt;
		logic [`ATS_CNT_W-1:0]   lmin_cnt;
		ats_drv_t                drv;
		logic                    awready;
		logic                    wready;
		logic                    aw_got;
		logic                    w_got;
		logic                    bvalid;
		logic [1:0]              bresp;
		logic [`ATS_ADDR_W-1:0]  awaddr;
		logic [31:0]             wdata;
		logic [3:0]              wstrb;
		logic                    arready;
		logic                    rvalid;
		logic [1:0]              rresp;
		logic [31:0]             rdata;
	} ats_state_t;
endpackage : ats_pkg
`default_nettype wire

// ### ats_sequencer.sv
// servo sequencer: tuning and fault latches, relay, servo directions, axi4-lite regs
//
// Summary of operation
// R1: tune request sets tuning latch
// R2: tune request energises attenuator relay
// R3: timeout sets fault latch and lamp
// R4: timeout clears tuning latch
// R5: low supply sense sets fault latch
// R6: nominal supply while tuning: clear tuning, fault
// R7: tuning without rf energises relay
// R8: idle with high reflection energises relay
// R9: timeout during force flags inductor maximum
// R10: phase sign steers capacitor direction
// R11: amplitude error steers inductor direction
// R12: below threshold removes drives, pulses brake
// R13: tune start sets both homing latches
// R14: positive phase over 50 clears homing
// R15: report lmin with cmax to stepper
// R16: force latch drives inductor toward maximum
// R17: otherwise drives follow error indications, homing latches, lmin pulse and lmax
// R18: capacitor outputs: decrease phase, increase phase/home
// R19: inductor increase: low, force, lmin pulse
// R20: inductor decrease: home, high, lmax drive
// R21: detect lmin, zero phase, over 50
// R22: tuning set clears fault latch
// R23: inductor maximum energises attenuator relay
// R24: capacitor maximum clears capacitor homing
// R25: timeout counted in clocks while tuning
// R26: all pin inputs double synchronised
`timescale 1ns/1ps
`default_nettype none
`include "ats_params.svh"
module ats_sequencer
	import ats_pkg::*;
#(
	parameter logic [31:0] TIMEOUT_CYC = `ATS_TIMEOUT_CYC
) (
	input  wire logic                   aclk,
	input  wire logic                   aresetn,
	input  wire ats_det_t               det_in,
	output var  ats_drv_t               drv_out,
	input  wire logic [`ATS_ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                   s_axi_awvalid,
	output var  logic                   s_axi_awready,
	input  wire logic [31:0]            s_axi_wdata,
	input  wire logic [3:0]             s_axi_wstrb,
	input  wire logic                   s_axi_wvalid,
	output var  logic                   s_axi_wready,
	output var  logic [1:0]             s_axi_bresp,
	output var  logic                   s_axi_bvalid,
	input  wire logic                   s_axi_bready,
	input  wire logic [`ATS_ADDR_W-1:0] s_axi_araddr,
	input  wire logic                   s_axi_arvalid,
	output var  logic                   s_axi_arready,
	output var  logic [31:0]            s_axi_rdata,
	output var  logic [1:0]             s_axi_rresp,
	output var  logic                   s_axi_rvalid,
	input  wire logic                   s_axi_rready
);

	ats_state_t st_r;
	ats_state_t st_nxt;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] be);
		logic [31:0] m;
		m = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				m[8*i +: 8] = d[8*i +: 8];
			end
		end
		return m;
	endfunction : merge

	//****************************************************
	// sequencing and direction logic
	//****************************************************
	always_comb begin
		ats_det_t d;
		ats_det_t p;
		logic     tune_go;
		logic     tune_rise;
		logic     expire;
		logic     pos_hi;
		logic     lmin_cmax;
		logic     below;
		logic     lmax_eff;
		logic     drive_en;
		logic     hang;
		d         = '0;
		p         = '0;
		tune_go   = 1'b0;
		tune_rise = 1'b0;
		expire    = 1'b0;
		pos_hi    = 1'b0;
		lmin_cmax = 1'b0;
		below     = 1'b0;
		lmax_eff  = 1'b0;
		drive_en  = 1'b0;
		hang      = 1'b0;
		st_nxt    = st_r;
		// first stage only feeds second; p is the previous synced sample
		st_nxt.s1 = det_in;
		st_nxt.s2 = st_r.s1; // [R26]
		st_nxt.s3 = st_r.s2;
		d         = st_r.s2;
		p         = st_r.s3;

		tune_rise = d.tune_request & ~p.tune_request;
		tune_go   = tune_rise | st_r.sw_tune; // [R1]
		expire    = st_r.tuning & (st_r.timer >= st_r.tmo); // [R25]
		pos_hi    = d.phase_pos & d.amp_hi;
		lmin_cmax = d.ind_min & d.cap_max;
		below     = st_r.tuning & d.below_level;
		lmax_eff  = d.ind_max | st_r.max_flag;
		st_nxt.sw_tune = 1'b0;

		// tuning latch and timer
		if (tune_go) begin
			st_nxt.tuning = 1'b1; // [R1]
			st_nxt.timer  = '0; // [R25]
		end else if (expire) begin
			st_nxt.tuning = 1'b0; // [R4]
		end else if (d.nominal_supply_sense & ~p.nominal_supply_sense & st_r.tuning) begin
			st_nxt.tuning = 1'b0; // [R6]
		end else if (st_r.tuning) begin
			st_nxt.timer = st_r.timer + `ATS_ONE_TMR; // [R25]
		end else begin
			st_nxt.timer = '0;
		end

		// fault latch: a set in the same cycle as the tune clear wins
		if (tune_go) begin
			st_nxt.fault = 1'b0; // [R22]
		end
		if (expire) begin
			st_nxt.fault = 1'b1; // [R3]
		end
		if (d.switched_low_supply_sense & ~p.switched_low_supply_sense) begin
			st_nxt.fault = 1'b1; // [R5]
		end
		if (d.nominal_supply_sense & ~p.nominal_supply_sense & st_r.tuning) begin
			st_nxt.fault = 1'b1; // [R6]
		end

		// homing latches; tune start wins over a clear in the same cycle
		if (pos_hi) begin
			st_nxt.cap_home = 1'b0; // [R14]
			st_nxt.ind_home = 1'b0; // [R14]
		end
		if (d.cap_max) begin
			st_nxt.cap_home = 1'b0; // [R24]
		end
		if (tune_go) begin
			st_nxt.cap_home = 1'b1; // [R13]
			st_nxt.ind_home = 1'b1; // [R13]
		end

		// inductor force latch and forced maximum
		if (pos_hi) begin
			st_nxt.ind_force = 1'b0; // [R16]
		end
		if (lmin_cmax & st_r.tuning) begin
			st_nxt.ind_force = 1'b1; // [R16]
		end
		if (expire & st_r.ind_force) begin
			st_nxt.max_flag  = 1'b1; // [R9]
			st_nxt.ind_force = 1'b0; // [R9]
		end
		if (tune_go) begin
			st_nxt.max_flag = 1'b0;
		end
		if (~st_r.tuning & ~tune_go) begin
			st_nxt.ind_force = 1'b0;
			st_nxt.cap_home  = 1'b0;
			st_nxt.ind_home  = 1'b0;
		end

		// brake pulse on the below-threshold pair, once per low pulse
		if (below & ~d.below_pulse_n & p.below_pulse_n) begin
			st_nxt.brake_cnt = `ATS_CNT_W'(`ATS_BRAKE_CYC); // [R12]
		end else if (st_r.brake_cnt != '0) begin
			st_nxt.brake_cnt = st_r.brake_cnt - `ATS_ONE_CNT;
		end

		// kick off the minimum switch when the inductor lands on it while not homing
		if (st_r.tuning & d.ind_min & ~p.ind_min & ~st_r.ind_home) begin
			st_nxt.lmin_cnt = `ATS_CNT_W'(`ATS_LMIN_CYC); // [R19]
		end else if (st_r.lmin_cnt != '0) begin
			st_nxt.lmin_cnt = st_r.lmin_cnt - `ATS_ONE_CNT;
		end

		// hang-up: blocked at cmax and while the capacitor is homing
		hang = st_r.tuning & d.ind_min & ~d.phase_pos & ~d.phase_neg & d.amp_hi
			& ~d.cap_max & ~st_r.cap_home; // [R21]

		// below threshold overrides any residual error
		drive_en = st_r.tuning & ~below & (st_r.brake_cnt == '0); // [R12] [R17]
		st_nxt.drv.cap_dec = drive_en & d.phase_pos; // [R10] [R18]
		st_nxt.drv.cap_inc = drive_en & (d.phase_neg | st_r.cap_home); // [R10] [R18]
		st_nxt.drv.ind_inc = drive_en & (d.amp_lo | st_r.ind_force
			| (st_r.lmin_cnt != '0)); // [R11] [R16] [R19]
		st_nxt.drv.ind_dec = drive_en & (st_r.ind_home | d.amp_hi | lmax_eff); // [R11] [R20]
		st_nxt.drv.brake   = (st_r.brake_cnt != '0); // [R12]
		st_nxt.drv.atten_relay = d.tune_request | tune_go // [R2]
			| (st_r.tuning & ~d.rf_present) // [R7]
			| (~st_r.tuning & d.refl_over) // [R8]
			| lmax_eff; // [R23]
		st_nxt.drv.tuning_lamp = st_r.tuning;
		st_nxt.drv.fault_lamp  = st_r.fault; // [R3]
		st_nxt.drv.lmin_cmax   = lmin_cmax; // [R15]
		st_nxt.drv.hangup      = hang; // [R21]

		//****************************************************
		// axi4-lite slave
		//****************************************************
		if (s_axi_awvalid & st_r.awready) begin
			st_nxt.aw_got = 1'b1;
			st_nxt.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid & st_r.wready) begin
			st_nxt.w_got = 1'b1;
			st_nxt.wdata = s_axi_wdata;
			st_nxt.wstrb = s_axi_wstrb;
		end
		if (st_r.bvalid & s_axi_bready) begin
			st_nxt.bvalid = 1'b0;
		end
		if (st_r.aw_got & st_r.w_got & ~st_r.bvalid) begin
			st_nxt.aw_got = 1'b0;
			st_nxt.w_got  = 1'b0;
			st_nxt.bvalid = 1'b1;
			st_nxt.bresp  = `ATS_RESP_OKAY;
			if (st_r.awaddr == `ATS_REG_CTRL) begin
				st_nxt.sw_tune = st_r.wstrb[0] & st_r.wdata[`ATS_CTRL_TUNE_BIT];
			end else if (st_r.awaddr == `ATS_REG_TIMEOUT) begin
				st_nxt.tmo = merge(st_r.tmo, st_r.wdata, st_r.wstrb);
			end else if (st_r.awaddr == `ATS_REG_STATUS) begin
				st_nxt.bresp = `ATS_RESP_OKAY;
			end else begin
				st_nxt.bresp = `ATS_RESP_SLVERR;
			end
		end
		// one write in flight: each channel closes once its beat is held
		st_nxt.awready = ~st_nxt.aw_got & ~st_nxt.bvalid;
		st_nxt.wready  = ~st_nxt.w_got & ~st_nxt.bvalid;

		if (st_r.rvalid & s_axi_rready) begin
			st_nxt.rvalid = 1'b0;
		end
		if (s_axi_arvalid & st_r.arready) begin
			st_nxt.rvalid = 1'b1;
			st_nxt.rresp  = `ATS_RESP_OKAY;
			st_nxt.rdata  = '0;
			if (s_axi_araddr == `ATS_REG_CTRL) begin
				st_nxt.rdata = '0;
			end else if (s_axi_araddr == `ATS_REG_TIMEOUT) begin
				st_nxt.rdata = st_r.tmo;
			end else if (s_axi_araddr == `ATS_REG_STATUS) begin
				st_nxt.rdata = {22'h00_0000, st_r.max_flag, st_r.ind_force, st_r.ind_home,
					st_r.cap_home, st_r.fault, st_r.tuning, st_r.drv[3:0]};
			end else begin
				st_nxt.rresp = `ATS_RESP_SLVERR;
			end
		end
		st_nxt.arready = ~st_nxt.rvalid;
	end

	//****************************************************
	// state register
	//****************************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_r     <= '0;
			st_r.tmo <= TIMEOUT_CYC;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign drv_out       = st_r.drv;
	assign s_axi_awready = st_r.awready;
	assign s_axi_wready  = st_r.wready;
	assign s_axi_bvalid  = st_r.bvalid;
	assign s_axi_bresp   = st_r.bresp;
	assign s_axi_arready = st_r.arready;
	assign s_axi_rvalid  = st_r.rvalid;
	assign s_axi_rdata   = st_r.rdata;
	assign s_axi_rresp   = st_r.rresp;

endmodule : ats_sequencer
`default_nettype wire

// ### ats_partner.sv
// far side model: detectors as set by the bench, series capacitor stepper
`timescale 1ns/1ps
`default_nettype none
module ats_partner
	import ats_pkg::*;
(
	input  wire logic       aclk,
	input  wire ats_drv_t   drv,
	input  wire ats_det_t   ext,
	output var  ats_det_t   det,
	output var  logic [7:0] steps
);
	// ****
	// stepper
	// ****
	logic lc_q = 1'b0;
	initial steps = 8'h00;
	assign det = ext;
	// one step per fresh report; home position is the stepper's own business
	always @(posedge aclk) begin
		lc_q <= drv.lmin_cmax;
		if (drv.lmin_cmax && !lc_q) steps <= steps + 8'h01;
	end
endmodule : ats_partner
`default_nettype wire

// ### ats_sequencer_checker.sv
// pin level assertions for the servo sequencer
`timescale 1ns/1ps
`default_nettype none
module ats_sequencer_checker
	import ats_pkg::*;
(
	input wire logic     aclk,
	input wire logic     aresetn,
	input wire ats_det_t det_in,
	input wire ats_drv_t drv_out
);
	// ****
	// properties
	// ****
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	logic [3:0] dirs;
	assign dirs = {drv_out.cap_dec, drv_out.cap_inc, drv_out.ind_inc, drv_out.ind_dec};
	sequence s_lc;
		(det_in.ind_min && det_in.cap_max) [*4];
	endsequence
	property p_tune;
		$rose(det_in.tune_request) |-> ##[3:5] drv_out.tuning_lamp;
	endproperty
	a_tune: assert property (p_tune) else $error("tuning missing");
	property p_low;
		$rose(det_in.switched_low_supply_sense) |-> ##[3:5] drv_out.fault_lamp;
	endproperty
	a_low: assert property (p_low) else $error("fault missing");
	property p_nom;
		$rose(det_in.nominal_supply_sense) && drv_out.tuning_lamp
			|-> ##[3:5] !drv_out.tuning_lamp && drv_out.fault_lamp;
	endproperty
	a_nom: assert property (p_nom) else $error("nominal supply ignored");
	property p_cap;
		drv_out.cap_dec |-> $past(det_in.phase_pos, 3);
	endproperty
	a_cap: assert property (p_cap) else $error("cap_dec without phase");
	property p_brk;
		drv_out.brake |-> dirs == 4'h0;
	endproperty
	a_brk: assert property (p_brk) else $error("drive during brake");
	property p_idle;
		!drv_out.tuning_lamp |-> dirs == 4'h0;
	endproperty
	a_idle: assert property (p_idle) else $error("drive while idle");
	property p_lc;
		s_lc ##0 drv_out.tuning_lamp |-> drv_out.lmin_cmax;
	endproperty
	a_lc: assert property (p_lc) else $error("lmin_cmax missing");
	property p_home;
		$rose(drv_out.tuning_lamp) |-> dirs[2] && dirs[0];
	endproperty
	a_home: assert property (p_home) else $error("homing missing");
endmodule : ats_sequencer_checker
bind ats_sequencer ats_sequencer_checker i_chk (.aclk(aclk), .aresetn(aresetn),
	.det_in(det_in), .drv_out(drv_out));
`default_nettype wire

// ### ats_sequencer_tb.sv
// self-checking bench for the servo sequencer
`timescale 1ns/1ps
`default_nettype none
`include "ats_params.svh"
module ats_sequencer_tb
	import ats_pkg::*;
;
	// ****
	// bench
	// ****
	localparam logic [31:0] T = 32'h0000_0032;
	logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0, awready, wready, bvalid, arready, rvalid;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00, steps;
	logic [31:0] wdata = 32'h0, rdata;
	logic [1:0] bresp, rresp;
	logic [3:0] dirs;
	ats_det_t ext = '0, det;
	ats_drv_t drv;
	int mismatches = 0, n_checks = 0, on_cnt = 0, last_on = 0, n;
	assign dirs = {drv.cap_dec, drv.cap_inc, drv.ind_inc, drv.ind_dec};
	always #2.5 aclk = ~aclk;
	always @(posedge aclk) begin
		on_cnt <= (drv.tuning_lamp === 1'b1) ? on_cnt + 1 : 0;
		if (drv.tuning_lamp === 1'b0 && on_cnt != 0) last_on <= on_cnt;
	end
	ats_sequencer #(.TIMEOUT_CYC(T)) i_ats_sequencer (.aclk(aclk), .aresetn(aresetn),
		.det_in(det), .drv_out(drv), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
	ats_partner i_ats_partner (.aclk(aclk), .drv(drv), .ext(ext), .det(det), .steps(steps));
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic wt(input int k);
		repeat (k) @(posedge aclk);
	endtask : wt
	// address and data offered together, taken in either order
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic ga, gw;
		ga = 1'b0;
		gw = 1'b0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(ga && gw)) begin
			@(posedge aclk);
			if (awready === 1'b1) ga = 1'b1;
			if (wready === 1'b1) gw = 1'b1;
			if (ga) awvalid <= 1'b0;
			if (gw) wvalid <= 1'b0;
		end
		while (bvalid !== 1'b1) @(posedge aclk);
		chk("bresp", er, bresp);
		bready <= 1'b0;
		@(posedge aclk);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e, m, input logic [1:0] er);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		@(posedge aclk);
		while (arready !== 1'b1) @(posedge aclk);
		arvalid <= 1'b0;
		while (rvalid !== 1'b1) @(posedge aclk);
		chk("rdata", e, rdata & m);
		chk("rresp", er, rresp);
		rready <= 1'b0;
		@(posedge aclk);
	endtask : rd
	task automatic wlamp();
		for (n = 0; n < 200 && drv.tuning_lamp !== 1'b0; n++) @(posedge aclk);
	endtask : wlamp
	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : stop_test
	initial begin
		#100us;
		mismatches++;
		stop_test();
	end
	initial begin
		ext.rf_present <= 1'b1;
		ext.below_pulse_n <= 1'b1;
		wt(6);
		aresetn <= 1'b1;
		wt(2);
		rd(`ATS_REG_TIMEOUT, T, 32'hffff_ffff, `ATS_RESP_OKAY);
		rd(8'h0c, 32'h0, 32'hffff_ffff, `ATS_RESP_SLVERR);
		wr(8'h0c, 32'h1, `ATS_RESP_SLVERR);
		rd(`ATS_REG_CTRL, 32'h0, 32'hffff_ffff, `ATS_RESP_OKAY);
		wr(`ATS_REG_STATUS, 32'h0000_03ff, `ATS_RESP_OKAY);
		rd(`ATS_REG_STATUS, 32'h0, 32'hffff_ffff, `ATS_RESP_OKAY);
		ext.tune_request <= 1'b1;
		wt(4);
		chk("relay", 1'b1, drv.atten_relay);
		ext.tune_request <= 1'b0;
		wt(4);
		chk("tune", 1'b1, drv.tuning_lamp);
		chk("home", 4'h5, dirs);
		ext.phase_pos <= 1'b1;
		ext.amp_hi <= 1'b1;
		wt(6);
		chk("unhome", 4'h9, dirs);
		chk("rf", 1'b0, drv.atten_relay);
		ext.phase_pos <= 1'b0;
		ext.ind_min <= 1'b1;
		wt(6);
		chk("hang", 1'b1, drv.hangup);
		chk("kick", 1'b1, drv.ind_inc);
		{ext.ind_min, ext.amp_hi, ext.phase_neg, ext.amp_lo, ext.rf_present} <= 5'h06;
		wt(6);
		chk("err", 4'h6, dirs);
		chk("norf", 1'b1, drv.atten_relay);
		ext.rf_present <= 1'b1;
		wlamp();
		chk("tmo", 1'b1, drv.fault_lamp);
		wr(`ATS_REG_TIMEOUT, 32'h0000_2000, `ATS_RESP_OKAY);
		wr(`ATS_REG_CTRL, 32'h1, `ATS_RESP_OKAY);
		wt(3);
		chk("retune", 2'b10, {drv.tuning_lamp, drv.fault_lamp});
		{ext.phase_neg, ext.amp_lo, ext.below_level} <= 3'h1;
		wt(5);
		chk("below", 4'h0, dirs);
		ext.below_pulse_n <= 1'b0;
		wt(3);
		ext.below_pulse_n <= 1'b1;
		for (n = 0; n < 20 && drv.brake !== 1'b1; n++) @(posedge aclk);
		for (n = 0; n < 3000 && drv.brake === 1'b1; n++) @(posedge aclk);
		chk("brake", `ATS_BRAKE_CYC, n);
		{ext.below_level, ext.ind_min, ext.cap_max, ext.phase_neg, ext.amp_hi} <= 5'h0f;
		wt(6);
		chk("lc", 1'b1, drv.lmin_cmax);
		chk("step", 8'h01, steps);
		chk("force", 1'b1, drv.ind_inc);
		wr(`ATS_REG_TIMEOUT, T, `ATS_RESP_OKAY);
		wt(4);
		rd(`ATS_REG_STATUS, 32'h0000_0224, 32'h0000_033c, `ATS_RESP_OKAY);
		chk("lmax", 1'b1, drv.atten_relay);
		{ext.ind_min, ext.cap_max, ext.phase_neg, ext.amp_hi} <= 4'h0;
		wr(`ATS_REG_CTRL, 32'h1, `ATS_RESP_OKAY);
		wt(3);
		chk("fclr", 1'b0, drv.fault_lamp);
		ext.nominal_supply_sense <= 1'b1;
		wt(6);
		chk("nom", 2'b01, {drv.tuning_lamp, drv.fault_lamp});
		ext.nominal_supply_sense <= 1'b0;
		wr(`ATS_REG_CTRL, 32'h1, `ATS_RESP_OKAY);
		wt(3);
		ext.switched_low_supply_sense <= 1'b1;
		wt(6);
		chk("low", 1'b1, drv.fault_lamp);
		wlamp();
		wt(1);
		chk("span", 1'b1, last_on >= T && last_on <= T + 2);
		ext.refl_over <= 1'b1;
		wt(6);
		chk("refl", 1'b1, drv.atten_relay);
		stop_test();
	end
endmodule : ats_sequencer_tb
`default_nettype wire
